// file: design/fps_lock_level.sv
// Purpose: decode three lock bits into protection enables
// Assumes: programmed bit reads as 0
// Notes:   lock bits are only changed by the parallel programmer
module fps_lock_level (
	input  wire logic [2:0] lock_bits,     // lock bit two..zero
	output logic            block_ext_code_move_instr, // external code reads of internal bytes
	output logic            latch_ea,       // latch external access pin at reset
	output logic            block_par_prog, // parallel flash programming blocked
	output logic            block_par_wr,   // parallel data memory writes blocked
	output logic            block_verify,   // parallel verify and data reads blocked
	output logic            block_ext_exec  // external execution blocked
);
	logic [2:0] level;
	// highest programmed bit wins: level 1..4
	always_comb begin
		if (!lock_bits[2])
			level = 3'h4;
		else if (!lock_bits[1])
			level = 3'h3;
		else if (!lock_bits[0])
			level = 3'h2;
		else
			level = 3'h1;
	end
	// restrictions accumulate with level
	assign block_ext_code_move_instr = level >= 3'h2;
	assign latch_ea       = level >= 3'h2;
	assign block_par_prog = level >= 3'h2;
	assign block_par_wr   = level >= 3'h2;
	assign block_verify   = level >= 3'h3;
	assign block_ext_exec = level >= 3'h4;
endmodule : fps_lock_level

// file: design/fps_sequencer.sv
// Purpose: flash page program sequencer with page buffer and unlock codes
// Assumes: one control write per instruction; instr_strobe marks each instruction
// Notes:   flash array is outside; this block drives erase/program strobes
// Summary of operation
// - 50h then A0h launches user write
// - 52h then A2h launches extra row write
// - 54h then A4h launches security write
// - busy flag clears when write finishes
// - last loaded page address is programmed
// - buffer clears after successful write
// - 56h then A6h clears the buffer
// - 50h/52h/54h/56h not followed by matching Ax flags error
// - user or extra row launch with empty buffer flags error
// - error cleared by software or success
// - control 02h maps extra row reads
// - control 04h maps security byte read
// - three lock bits, default level four
// - level two blocks parallel programming
// - level three also blocks parallel verify
// - level four blocks external execution
// - programming starts second cycle, busy held
// - buffer writes ignored while busy
// - erase then program only loaded bytes
module fps_sequencer #(
	parameter int prog_cycles = fps_pkg::prog_cycles // program time in cycles
) (
	input  wire logic        clock,            // core clock
	input  wire logic        rst_b,            // synchronous reset
	input  wire logic        instr_strobe,     // one pulse per executed instruction
	input  wire logic        ctrl_wr,          // write to flash control register
	input  wire logic [7:0]  ctrl_wdata,       // control write data
	input  wire logic        from_boot_area,   // code runs from boot flash area
	input  wire logic        err_clear,        // software clears sequence error
	input  wire logic        buf_wr,           // page buffer store
	input  wire logic [15:0] buf_addr,         // page buffer store address
	input  wire logic [7:0]  buf_wdata,        // page buffer store data
	input  wire logic        code_rd,          // code space read
	input  wire logic [15:0] code_addr,        // code read address
	input  wire logic [7:0]  flash_rdata,      // user flash byte
	input  wire logic [7:0]  xrow_rdata,       // extra row byte
	input  wire logic        par_lock_wr,      // parallel mode lock write
	input  wire logic [2:0]  par_lock_data,    // new lock bits
	output logic [7:0]       flash_control_reg,// control register readback
	output logic [7:0]       flash_status_reg, // status register readback
	output logic             programming_in_progress, // busy flag
	output logic             sequence_error_flag,     // sequence error
	output logic             buffer_loaded_flag,      // buffer holds data
	output logic             buffer_space_map,        // buffer mapped for stores
	output logic [7:0]       code_rdata,       // mapped code read data
	output logic             fl_erase,         // erase strobe for one byte
	output logic             fl_prog,          // program strobe for one byte
	output logic [1:0]       fl_target,        // space being written
	output logic [15:0]      fl_addr,          // byte address being written
	output logic [7:0]       fl_wdata,         // byte being written
	output logic [2:0]       lock_bits,        // lock bits two..zero
	output logic             block_ext_code_move_instr,   // level 2 restriction
	output logic             latch_ea,         // level 2 restriction
	output logic             block_par_prog,   // level 2 restriction
	output logic             block_par_wr,     // level 2 restriction
	output logic             block_verify,     // level 3 restriction
	output logic             block_ext_exec    // level 4 restriction
);
	localparam int cw = $clog2(prog_cycles + 1);

	logic [7:0]                mem [fps_pkg::page_bytes];
	logic [fps_pkg::page_bytes-1:0] loaded;
	logic [8:0]                page;
	logic [7:0]                hsb_data;
	logic                      armed;
	logic [3:0]                armed_op;
	fps_pkg::fps_state_e       state;
	fps_pkg::fps_target_e      target;
	logic [1:0]                delay;
	logic [cw-1:0]             timer;
	logic [fps_pkg::page_aw-1:0] idx;
	logic                      launch;
	logic                      clear_cmd;
	logic                      bad_seq;
	logic                      empty_launch;
	logic                      done;
	logic                      buf_take;
	logic                      hsb_take;

	// true when a byte is the matching second unlock byte
	function automatic logic is_match(input logic [3:0] op, input logic [7:0] d);
		is_match = (d[7:4] == fps_pkg::launch_hi) && (d[3:0] == op);
	endfunction : is_match

	// true when a code is a known first unlock byte
	function automatic logic is_first(input logic [7:0] d);
		is_first = (d[7:4] == fps_pkg::unlock_hi) && (d[3:0] == fps_pkg::op_user
			|| d[3:0] == fps_pkg::op_xrow || d[3:0] == fps_pkg::op_hsb
			|| d[3:0] == fps_pkg::op_clear);
	endfunction : is_first

	// unlock decode: second byte on the next instruction completes it
	always_comb begin
		launch    = 1'b0;
		clear_cmd = 1'b0;
		bad_seq   = 1'b0;
		if (armed && ctrl_wr && from_boot_area && is_match(armed_op, ctrl_wdata)) begin
			if (armed_op == fps_pkg::op_clear)
				clear_cmd = 1'b1;
			else
				launch = 1'b1;
		end else if (armed && instr_strobe) begin
			bad_seq = 1'b1;
		end
	end
	assign empty_launch = launch && (loaded == '0) && (armed_op != fps_pkg::op_hsb);
	assign buf_take = buf_wr && buffer_space_map && !programming_in_progress
		&& flash_control_reg[2:1] == 2'b00;
	assign hsb_take = buf_wr && flash_control_reg == fps_pkg::map_hsb_load
		&& buf_addr == fps_pkg::hsb_addr && !programming_in_progress;

	// arm on a first unlock byte from the boot area
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			armed     <= 1'b0;
			armed_op  <= 4'h0;
		end else if (ctrl_wr && is_first(ctrl_wdata) && from_boot_area
			&& !programming_in_progress) begin
			armed     <= 1'b1;
			armed_op  <= ctrl_wdata[3:0];
		end else if (launch || clear_cmd || bad_seq) begin
			armed     <= 1'b0;
		end
	end

	// control register: plain writes are mapping values, unlock bytes are not stored
	always_ff @(posedge clock) begin
		if (!rst_b)
			flash_control_reg <= fps_pkg::ctrl_reset;
		else if (ctrl_wr && ctrl_wdata[7:4] != fps_pkg::unlock_hi
			&& ctrl_wdata[7:4] != fps_pkg::launch_hi)
			flash_control_reg <= ctrl_wdata;
	end
	assign buffer_space_map = flash_control_reg[fps_pkg::map_bit];

	// sequence error: hardware set wins over any clear
	always_ff @(posedge clock) begin
		if (!rst_b)
			sequence_error_flag <= 1'b0;
		else if (bad_seq || empty_launch)
			sequence_error_flag <= 1'b1;
		else if (err_clear || done)
			sequence_error_flag <= 1'b0;
	end

	// page buffer contents and loaded marks
	always_ff @(posedge clock) begin
		if (!rst_b || done || clear_cmd) begin
			loaded <= '0;
		end else if (buf_take) begin
			mem[buf_addr[fps_pkg::page_aw-1:0]]    <= buf_wdata;
			loaded[buf_addr[fps_pkg::page_aw-1:0]] <= 1'b1;
		end
	end
	// loaded flag follows any mark or a security byte capture
	always_ff @(posedge clock) begin
		if (!rst_b || done || clear_cmd)
			buffer_loaded_flag <= 1'b0;
		else if (buf_take || hsb_take)
			buffer_loaded_flag <= 1'b1;
	end
	// page of last store selects the programmed page
	always_ff @(posedge clock) begin
		if (!rst_b)
			page <= 9'h000;
		else if (buf_take)
			page <= buf_addr[15:fps_pkg::page_aw];
	end
	// security byte capture and lock bits
	always_ff @(posedge clock) begin
		if (!rst_b)
			hsb_data <= 8'hff;
		else if (hsb_take)
			hsb_data <= buf_wdata;
	end
	always_ff @(posedge clock) begin
		if (!rst_b)
			lock_bits <= fps_pkg::lock_reset;
		else if (par_lock_wr)
			lock_bits <= par_lock_data;
	end

	// write engine: wait, then per byte erase and program
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state  <= fps_pkg::fps_idle;
			target <= fps_pkg::fps_tgt_user;
			delay  <= 2'h0;
			timer  <= '0;
			idx    <= '0;
		end else begin
			case (state)
				fps_pkg::fps_idle: begin
					if (launch && !empty_launch) begin
						state <= fps_pkg::fps_wait;
						delay <= fps_pkg::launch_delay_c - 2'h1;
						idx   <= '0;
						case (armed_op)
							fps_pkg::op_xrow: target <= fps_pkg::fps_tgt_xrow;
							fps_pkg::op_hsb:  target <= fps_pkg::fps_tgt_hsb;
							default:          target <= fps_pkg::fps_tgt_user;
						endcase
					end
				end
				fps_pkg::fps_wait: begin
					if (delay == 2'h1)
						state <= fps_pkg::fps_erase;
					delay <= delay - 2'h1;
				end
				fps_pkg::fps_erase: begin
					state <= fps_pkg::fps_prog;
					timer <= cw'(prog_cycles - 1);
				end
				fps_pkg::fps_prog: begin
					if (timer != '0) begin
						timer <= timer - cw'(1);
					end else if (idx == fps_pkg::page_aw'(fps_pkg::page_bytes - 1)
						|| target == fps_pkg::fps_tgt_hsb) begin
						state <= fps_pkg::fps_idle;
					end else begin
						idx   <= idx + fps_pkg::page_aw'(1);
						state <= fps_pkg::fps_erase;
					end
				end
				default: state <= fps_pkg::fps_idle;
			endcase
		end
	end
	assign done = state == fps_pkg::fps_prog && timer == '0
		&& (idx == fps_pkg::page_aw'(fps_pkg::page_bytes - 1)
		|| target == fps_pkg::fps_tgt_hsb);
	assign programming_in_progress = state != fps_pkg::fps_idle;
	assign fl_target = target;

	// array strobes only for loaded bytes or the security byte
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			fl_erase <= 1'b0;
			fl_prog  <= 1'b0;
			fl_addr  <= 16'h0000;
			fl_wdata <= 8'h00;
		end else begin
			fl_erase <= state == fps_pkg::fps_erase
				&& (loaded[idx] || target == fps_pkg::fps_tgt_hsb);
			fl_prog  <= state == fps_pkg::fps_prog && timer == cw'(prog_cycles - 1)
				&& (loaded[idx] || target == fps_pkg::fps_tgt_hsb);
			fl_addr  <= (target == fps_pkg::fps_tgt_hsb) ? fps_pkg::hsb_addr
				: {page, idx};
			fl_wdata <= (target == fps_pkg::fps_tgt_hsb) ? hsb_data : mem[idx];
		end
	end

	// code read mapping
	always_ff @(posedge clock) begin
		if (!rst_b)
			code_rdata <= 8'h00;
		else if (code_rd) begin
			if (flash_control_reg == fps_pkg::map_xrow && code_addr >= fps_pkg::xrow_base)
				code_rdata <= xrow_rdata;
			else if (flash_control_reg == fps_pkg::map_hsb && code_addr == fps_pkg::hsb_addr)
				code_rdata <= {hsb_data[7:3], lock_bits};
			else
				code_rdata <= flash_rdata;
		end
	end

	assign flash_status_reg = {4'h0, buffer_loaded_flag, 1'b0, sequence_error_flag,
		programming_in_progress};

	fps_lock_level u_lock (
		.lock_bits      (lock_bits),
		.block_ext_code_move_instr (block_ext_code_move_instr),
		.latch_ea       (latch_ea),
		.block_par_prog (block_par_prog),
		.block_par_wr   (block_par_wr),
		.block_verify   (block_verify),
		.block_ext_exec (block_ext_exec)
	);

	// busy must come up on the cycle after a good launch
	a_launch_busy: assert property (@(posedge clock) disable iff (!rst_b)
		(launch && !empty_launch) |=> programming_in_progress)
		else $error("busy not raised after launch");
	// empty launch flags error and stays idle
	a_empty_error: assert property (@(posedge clock) disable iff (!rst_b)
		empty_launch && !programming_in_progress |=> sequence_error_flag
		&& !programming_in_progress)
		else $error("empty launch not flagged");
	// broken unlock sets error
	a_bad_sequence: assert property (@(posedge clock) disable iff (!rst_b)
		bad_seq |=> sequence_error_flag)
		else $error("bad sequence not flagged");
	// buffer empty after completion
	a_done_clear: assert property (@(posedge clock) disable iff (!rst_b)
		done |=> !buffer_loaded_flag && loaded == '0)
		else $error("buffer not cleared after write");
	// on demand clear
	a_cmd_clear: assert property (@(posedge clock) disable iff (!rst_b)
		clear_cmd |=> !buffer_loaded_flag)
		else $error("buffer not cleared on command");
	// buffer frozen while busy
	a_busy_frozen: assert property (@(posedge clock) disable iff (!rst_b)
		programming_in_progress && !done |=> $stable(loaded))
		else $error("buffer changed while busy");
	// busy drops after completion
	a_busy_end: assert property (@(posedge clock) disable iff (!rst_b)
		done |=> !programming_in_progress)
		else $error("busy held after completion");
	// unloaded bytes never programmed
	a_only_loaded: assert property (@(posedge clock) disable iff (!rst_b)
		fl_prog && target != fps_pkg::fps_tgt_hsb |-> $past(loaded[idx]))
		else $error("unloaded byte programmed");
	// level four forbids external execution
	a_level_four: assert property (@(posedge clock) disable iff (!rst_b)
		!lock_bits[2] |-> block_ext_exec && block_verify && block_par_prog)
		else $error("level four restrictions missing");
	// good launch, one wait cycle, then the first erase
	sequence s_good_launch;
		launch && !empty_launch;
	endsequence
	sequence s_wait_erase;
		state == fps_pkg::fps_wait ##1 state == fps_pkg::fps_erase;
	endsequence
	a_erase_second: assert property (@(posedge clock) disable iff (!rst_b)
		s_good_launch |=> s_wait_erase)
		else $error("erase not started on the second cycle");
	// extra row code selects the extra row space
	a_xrow_target: assert property (@(posedge clock) disable iff (!rst_b)
		launch && !empty_launch && armed_op == fps_pkg::op_xrow |=> fl_target == 2'h1)
		else $error("extra row launch wrong target");
	// security code selects the security byte
	a_hsb_target: assert property (@(posedge clock) disable iff (!rst_b)
		launch && !empty_launch && armed_op == fps_pkg::op_hsb |=> fl_target == 2'h2)
		else $error("security launch wrong target");
	// software clear takes effect when nothing sets
	a_err_clear: assert property (@(posedge clock) disable iff (!rst_b)
		err_clear && !bad_seq && !empty_launch |=> !sequence_error_flag)
		else $error("sequence error not cleared");
	// a taken store raises the loaded flag
	a_load_flag: assert property (@(posedge clock) disable iff (!rst_b)
		buf_take && !clear_cmd |=> buffer_loaded_flag)
		else $error("loaded flag not set by store");
endmodule : fps_sequencer

// file: shared/fps_pkg.sv
// Purpose: constants and types shared by the flash program sequencer
// Assumes: 200 MHz core clock, byte-wide control register writes
// Notes:   program time is a parameter of the top module
package fps_pkg;
	localparam int          page_bytes      = 128;
	localparam int          page_aw         = 7;
	localparam logic [3:0]  unlock_hi       = 4'h5;
	localparam logic [3:0]  launch_hi       = 4'ha;
	localparam logic [3:0]  op_user         = 4'h0;
	localparam logic [3:0]  op_xrow         = 4'h2;
	localparam logic [3:0]  op_hsb          = 4'h4;
	localparam logic [3:0]  op_clear        = 4'h6;
	localparam logic [7:0]  map_xrow        = 8'h02;
	localparam logic [7:0]  map_hsb         = 8'h04;
	localparam logic [7:0]  map_hsb_load    = 8'h0c;
	localparam logic [15:0] xrow_base       = 16'hff80;
	localparam logic [15:0] hsb_addr        = 16'h0000;
	localparam int          map_bit         = 3;
	localparam logic [7:0]  ctrl_reset      = 8'h00;
	localparam logic [2:0]  lock_reset      = 3'b011;
	localparam int          clock_mhz       = 200;
	localparam int          prog_time_us    = 2000;
	localparam int          prog_cycles     = prog_time_us * clock_mhz;
	localparam int          launch_delay    = 2;
	localparam logic [1:0]  launch_delay_c  = 2'h2;
	typedef enum logic [1:0] {
		fps_idle  = 2'b00,
		fps_wait  = 2'b01,
		fps_erase = 2'b10,
		fps_prog  = 2'b11
	} fps_state_e;
	typedef enum logic [1:0] {
		fps_tgt_user = 2'b00,
		fps_tgt_xrow = 2'b01,
		fps_tgt_hsb  = 2'b10
	} fps_target_e;
endpackage : fps_pkg

// file: testbench/fps_testbench.sv
// Purpose: self-checking bench for the flash program sequencer
// Assumes: short program time through prog_cycles, inputs driven 1 ns after the edge
// Notes:   a monitor counts erase strobes and checks every program strobe against the loaded buffer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int prog_cyc = 4;
	logic        clock, rst_b, instr_strobe, ctrl_wr, from_boot_area, err_clear;
	logic        buf_wr, code_rd, par_lock_wr;
	logic [7:0]  ctrl_wdata, buf_wdata, flash_rdata, xrow_rdata;
	logic [15:0] buf_addr, code_addr;
	logic [2:0]  par_lock_data;
	logic [7:0]  flash_control_reg, flash_status_reg, code_rdata, fl_wdata;
	logic        programming_in_progress, sequence_error_flag, buffer_loaded_flag;
	logic        buffer_space_map, fl_erase, fl_prog;
	logic [1:0]  fl_target;
	logic [15:0] fl_addr;
	logic [2:0]  lock_bits;
	logic        block_ext_code_move_instr, latch_ea, block_par_prog, block_par_wr, block_verify;
	logic        block_ext_exec;
	int          n_tests, miscompares, n_erase, n_prog, cycles;
	logic [31:0] lfsr;
	logic [7:0]  exp_data [128];
	logic        exp_valid [128];
	logic [8:0]  exp_page;
	logic [1:0]  exp_tgt;
	logic [7:0]  hsbv;
	logic [15:0] a;

	fps_sequencer #(.prog_cycles(prog_cyc)) dut (
		.clock(clock), .rst_b(rst_b), .instr_strobe(instr_strobe), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .from_boot_area(from_boot_area), .err_clear(err_clear),
		.buf_wr(buf_wr), .buf_addr(buf_addr), .buf_wdata(buf_wdata), .code_rd(code_rd),
		.code_addr(code_addr), .flash_rdata(flash_rdata), .xrow_rdata(xrow_rdata),
		.par_lock_wr(par_lock_wr), .par_lock_data(par_lock_data),
		.flash_control_reg(flash_control_reg), .flash_status_reg(flash_status_reg),
		.programming_in_progress(programming_in_progress),
		.sequence_error_flag(sequence_error_flag), .buffer_loaded_flag(buffer_loaded_flag),
		.buffer_space_map(buffer_space_map), .code_rdata(code_rdata), .fl_erase(fl_erase),
		.fl_prog(fl_prog), .fl_target(fl_target), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
		.lock_bits(lock_bits), .block_ext_code_move_instr(block_ext_code_move_instr), .latch_ea(latch_ea),
		.block_par_prog(block_par_prog), .block_par_wr(block_par_wr),
		.block_verify(block_verify), .block_ext_exec(block_ext_exec)
	);

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction : lfsr_next

	// expected protection enables from the lock bits
	function automatic logic [5:0] exp_block(input logic [2:0] lb);
		int lvl;
		lvl = (lb == 3'b110) ? 2 : (lb == 3'b101) ? 3 : (lb == 3'b011) ? 4 : 1;
		return {{4{lvl >= 2}}, lvl >= 3, lvl == 4};
	endfunction : exp_block

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	task automatic tick();
		@(posedge clock);
		#1;
	endtask : tick

	task automatic ctrl(input logic [7:0] d);
		ctrl_wr = 1'b1; ctrl_wdata = d; instr_strobe = 1'b1;
		tick();
		ctrl_wr = 1'b0; instr_strobe = 1'b0;
		tick();
	endtask : ctrl

	// unlock pair on consecutive instructions
	task automatic ctrl2(input logic [7:0] d0, input logic [7:0] d1);
		ctrl_wr = 1'b1; ctrl_wdata = d0; instr_strobe = 1'b1;
		tick();
		ctrl_wdata = d1;
		tick();
		ctrl_wr = 1'b0; instr_strobe = 1'b0;
	endtask : ctrl2

	task automatic store(input logic [15:0] ad, input logic [7:0] d, input logic upd);
		buf_wr = 1'b1; buf_addr = ad; buf_wdata = d; instr_strobe = 1'b1;
		tick();
		buf_wr = 1'b0; instr_strobe = 1'b0;
		tick();
		if (upd) begin
			exp_data[ad[6:0]] = d; exp_valid[ad[6:0]] = 1'b1; exp_page = ad[15:7];
		end
	endtask : store

	task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
		code_rd = 1'b1; code_addr = ad;
		tick();
		code_rd = 1'b0;
		chk(code_rdata, exp);
	endtask : rd

	// launch one write and follow it to completion
	task automatic run_write(input logic [3:0] lo, input logic [1:0] tgt);
		int cnt, k;
		cnt = 0;
		foreach (exp_valid[i]) cnt += int'(exp_valid[i]);
		exp_tgt = tgt; n_erase = 0; n_prog = 0;
		ctrl2({4'h5, lo}, {4'ha, lo});
		tick();
		chk(programming_in_progress, 1);
		store(16'h0003, 8'h77, 1'b0);
		k = 0;
		while (programming_in_progress === 1'b1 && k < 3000) begin
			tick();
			k++;
		end
		chk(programming_in_progress, 0);
		chk(n_prog, cnt);
		chk(n_erase, cnt);
		chk(buffer_loaded_flag, 0);
		chk(sequence_error_flag, 0);
		chk(flash_status_reg[1], 0);
		foreach (exp_valid[i]) exp_valid[i] = 1'b0;
	endtask : run_write

	// strobe monitor: page, target, data and erase-before-program order
	always @(posedge clock) begin
		if (rst_b === 1'b1 && fl_erase === 1'b1) n_erase++;
		if (rst_b === 1'b1 && fl_prog === 1'b1) begin
			chk(fl_addr[15:7], exp_page);
			chk(fl_target, exp_tgt);
			chk(exp_valid[fl_addr[6:0]], 1);
			chk(fl_wdata, exp_data[fl_addr[6:0]]);
			chk(n_erase > n_prog, 1);
			n_prog++;
		end
	end

	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		{instr_strobe, ctrl_wr, err_clear, buf_wr, code_rd, par_lock_wr} = 6'h00;
		{ctrl_wdata, buf_wdata, flash_rdata, xrow_rdata} = 32'h00000000;
		{buf_addr, code_addr, par_lock_data} = 35'h0;
		from_boot_area = 1'b1; rst_b = 1'b0; lfsr = 32'h8e14;
		n_tests = 0; miscompares = 0; n_erase = 0; n_prog = 0; cycles = 0;
		exp_page = 9'h000; exp_tgt = 2'h0; hsbv = 8'h00;
		foreach (exp_valid[i]) exp_valid[i] = 1'b0;
		foreach (exp_data[i]) exp_data[i] = 8'h00;
		repeat (4) @(posedge clock);
		#1 rst_b = 1'b1;
		// reset values
		chk({flash_control_reg, buffer_loaded_flag, sequence_error_flag}, 0);
		chk(lock_bits, 3'b011);
		chk({block_ext_code_move_instr, latch_ea, block_par_prog, block_par_wr, block_verify,
			block_ext_exec}, exp_block(3'b011));
		// user space pages, first one loaded across two pages
		ctrl(8'h08);
		for (int it = 0; it < 3; it++) begin
			if (it == 0) store(16'h0285, 8'h3c, 1'b1);
			lfsr = lfsr_next(lfsr);
			for (int n = 0; n <= int'(lfsr[2:0] % 3'h6); n++) begin
				lfsr = lfsr_next(lfsr);
				store({lfsr[24:16], lfsr[14:8]}, lfsr[7:0], 1'b1);
			end
			chk({flash_status_reg[3], flash_status_reg[1:0]}, 3'b100);
			run_write(4'h0, 2'h0);
		end
		// extra row window
		for (int n = 0; n < 4; n++) begin
			lfsr = lfsr_next(lfsr);
			store({9'h1ff, lfsr[14:8]}, lfsr[7:0], 1'b1);
		end
		run_write(4'h2, 2'h1);
		// security byte
		lfsr = lfsr_next(lfsr);
		hsbv = lfsr[7:0];
		ctrl(8'h0c);
		chk({flash_control_reg, buffer_space_map}, {8'h0c, 1'b1});
		store(16'h0000, hsbv, 1'b1);
		run_write(4'h4, 2'h2);
		// buffer reset on demand, then an empty launch
		ctrl(8'h08);
		store(16'h1234, 8'ha5, 1'b0);
		chk(buffer_loaded_flag, 1);
		ctrl2(8'h56, 8'ha6);
		tick();
		chk(buffer_loaded_flag, 0);
		n_prog = 0;
		ctrl2(8'h50, 8'ha0);
		repeat (20) tick();
		chk({programming_in_progress, sequence_error_flag, n_prog[0]}, 3'b010);
		err_clear = 1'b1;
		tick();
		err_clear = 1'b0;
		chk(sequence_error_flag, 0);
		// lone first byte, then success clears the flag
		ctrl(8'h50);
		ctrl(8'h08);
		chk(sequence_error_flag, 1);
		store(16'h4011, 8'h96, 1'b1);
		run_write(4'h0, 2'h0);
		// launch from outside the boot area is not taken
		from_boot_area = 1'b0;
		store(16'h2002, 8'h11, 1'b0);
		ctrl2(8'h50, 8'ha0);
		repeat (2) tick();
		chk(programming_in_progress, 0);
		from_boot_area = 1'b1;
		ctrl2(8'h56, 8'ha6);
		tick();
		chk({flash_status_reg[3], flash_status_reg[0]}, 2'b00);
		// read mapping
		lfsr = lfsr_next(lfsr);
		{flash_rdata, xrow_rdata} = lfsr[15:0];
		ctrl(8'h02);
		rd({9'h1ff, lfsr[22:16]}, xrow_rdata);
		rd(16'h1000, flash_rdata);
		ctrl(8'h04);
		code_rd = 1'b1; code_addr = 16'h0000;
		tick();
		code_rd = 1'b0;
		chk(code_rdata, {hsbv[7:3], 3'b011});
		ctrl(8'h00);
		rd(16'h0000, flash_rdata);
		// protection levels one to four
		for (int i = 0; i < 4; i++) begin
			par_lock_data = (i == 0) ? 3'b111 : (i == 1) ? 3'b110 : (i == 2) ? 3'b101 : 3'b011;
			par_lock_wr = 1'b1;
			tick();
			par_lock_wr = 1'b0;
			tick();
			chk(lock_bits, par_lock_data);
			chk({block_ext_code_move_instr, latch_ea, block_par_prog, block_par_wr, block_verify,
				block_ext_exec}, exp_block(par_lock_data));
		end
		summarize();
	end
endmodule : testbench
